// *** hdl/pwo_pkg.sv ***
// Shared constants and types of the PWM output override and status block
package pwo_pkg;
	localparam int N_CHAN = 4;
	localparam int N_CMP = 8;
	localparam int N_FAULT = 6;

	localparam logic [31:0] OFS_ISR2 = 32'h40020040;
	localparam logic [31:0] OFS_OVERRIDE = 32'h40020044;
	localparam logic [31:0] OFS_SELECT = 32'h40020048;
	localparam logic [31:0] OFS_SET_NOW = 32'h4002004C;
	localparam logic [31:0] OFS_CLEAR_NOW = 32'h40020050;
	localparam logic [31:0] OFS_SET_NEXT = 32'h40020054;
	localparam logic [31:0] OFS_CLEAR_NEXT = 32'h40020058;
	localparam logic [31:0] OFS_FAULT_MODE = 32'h4002005C;
	localparam logic [31:0] OFS_IRQ_MASK = 32'h400200F0;

	localparam int HIGH_LSB = 0;
	localparam int LOW_LSB = 16;
	localparam int FAULT_POLARITY_LSB = 0;
	localparam int FAULT_LATCH_MODE_LSB = 8;
	localparam int FAULT_FILTER_ENABLE_LSB = 16;
	localparam int ST_SYNC_UPDATE_WRITE_READY = 0;
	localparam int ST_DMA_TRANSMIT_END = 1;
	localparam int ST_DMA_BUFFER_EMPTY = 2;
	localparam int ST_SYNC_UPDATE_UNDERRUN = 3;
	localparam int ST_CMPM_LSB = 8;
	localparam int ST_CMPU_LSB = 16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [N_CHAN-1:0] high;
		logic [N_CHAN-1:0] low;
	} pwo_pins_t;

	typedef struct packed {
		logic write_ready;
		logic underrun;
		logic counter_zero;
		logic program_write;
		logic buffer_empty;
		logic [N_CMP-1:0] cmp_match;
		logic [N_CMP-1:0] cmp_update;
	} pwo_events_t;

	typedef struct packed {
		logic sync_update_write_ready;
		logic dma_transmit_end;
		logic dma_buffer_empty;
		logic sync_update_underrun;
		logic [N_CMP-1:0] cmpm;
		logic [N_CMP-1:0] cmpu;
	} pwo_status_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_held;
		logic [31:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [N_CHAN-1:0] ovr_high;
		logic [N_CHAN-1:0] ovr_low;
		logic [N_CHAN-1:0] sel_high;
		logic [N_CHAN-1:0] sel_low;
		logic [N_CHAN-1:0] pend_set_high;
		logic [N_CHAN-1:0] pend_set_low;
		logic [N_CHAN-1:0] pend_clr_high;
		logic [N_CHAN-1:0] pend_clr_low;
		logic [N_FAULT-1:0] fmr_pol;
		logic [N_FAULT-1:0] fmr_latch;
		logic [N_FAULT-1:0] fmr_filt;
		logic [N_FAULT-1:0] fin_meta;
		logic [N_FAULT-1:0] fin_sync;
		logic [N_FAULT-1:0] fin_h1;
		logic [N_FAULT-1:0] fin_h2;
		logic [N_FAULT-1:0] fin_filt;
		logic [N_FAULT-1:0] fault_act;
		pwo_status_t st;
		logic [31:0] irq_mask;
		logic irq;
		pwo_pins_t pins;
	} pwo_state_t;

	// Fault sampling stages start at the pulled-up idle level of the fault lines
	localparam logic [N_FAULT-1:0] FAULT_IDLE = '1;
	localparam pwo_state_t STATE_RESET = '{fin_meta: FAULT_IDLE, fin_sync: FAULT_IDLE,
		fin_h1: FAULT_IDLE, fin_h2: FAULT_IDLE, fin_filt: FAULT_IDLE, default: '0};
endpackage

// *** hdl/pwo_top.sv ***
// PWM output override stage, second interrupt status and fault mode
// What this block does
// - Write-ready flag set when synchronous duty and dead-time writes become accepted, sticky until status read.
// - End-of-buffer flag set when DMA counter hits zero, cleared by DMA programming.
// - Underrun flag is sticky until the status register is read.
// - Each comparison has a sticky match flag since last status read.
// - Each comparison has a sticky update flag since last status read.
// - Status read clears write-ready, underrun and comparison flags.
// - Override levels per channel: high side bits 0-3, low side bits 16-19.
// - Selection bit 0 routes dead-time output, 1 routes override level.
// - Set-now register ones switch outputs to override at once.
// - Clear-now register ones switch outputs back to dead-time at once.
// - Deferred set ones switch to override at the channel's next period start.
// - Deferred clear ones return to dead-time at the channel's next period start.
// - Fault mode writes ignored while either group five protect bit is set.
// - Fault polarity bit picks the active input level.
// - Latched fault stays until condition gone and software clears it.
// - Filter bit enables input filtering for that fault.
`timescale 1ns/10ps
`default_nettype none
module pwo_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire pwo_pkg::pwo_pins_t deadtime,
	input wire logic [pwo_pkg::N_CHAN-1:0] period_start,
	input wire pwo_pkg::pwo_events_t events,
	input wire logic [pwo_pkg::N_FAULT-1:0] fault_in,
	input wire logic [pwo_pkg::N_FAULT-1:0] fault_clear,
	input wire logic soft_protect_group_five,
	input wire logic hard_protect_group_five,
	output var pwo_pkg::pwo_pins_t pins,
	output logic [pwo_pkg::N_FAULT-1:0] fault_active,
	output logic irq
);
	import pwo_pkg::*;

	pwo_state_t s;
	pwo_state_t next_s;
	logic wr_fire;
	logic rd_take;
	logic isr_read;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic [N_FAULT-1:0] fin_used;
	logic [N_FAULT-1:0] fault_cond;

	function automatic logic [31:0] status_image(input pwo_status_t st);
		logic [31:0] img;
		img = 32'h0;
		img[ST_SYNC_UPDATE_WRITE_READY] = st.sync_update_write_ready;
		img[ST_DMA_TRANSMIT_END] = st.dma_transmit_end;
		img[ST_DMA_BUFFER_EMPTY] = st.dma_buffer_empty;
		img[ST_SYNC_UPDATE_UNDERRUN] = st.sync_update_underrun;
		img[ST_CMPM_LSB +: N_CMP] = st.cmpm;
		img[ST_CMPU_LSB +: N_CMP] = st.cmpu;
		return img;
	endfunction

	function automatic logic [31:0] pair_image(input logic [N_CHAN-1:0] hi,
			input logic [N_CHAN-1:0] lo);
		logic [31:0] img;
		img = 32'h0;
		img[HIGH_LSB +: N_CHAN] = hi;
		img[LOW_LSB +: N_CHAN] = lo;
		return img;
	endfunction

	assign wr_fire = s.aw_held && s.w_held && !s.bvalid;
	assign rd_take = arvalid && s.arready;
	assign isr_read = rd_take && (araddr == OFS_ISR2);
	assign wmask = {{8{s.w_strb[3]}}, {8{s.w_strb[2]}}, {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};
	assign wdat = s.w_data & wmask;

	// Per-input polarity and optional filtering
	genvar y;
	generate
		for (y = 0; y < N_FAULT; y++) begin : g_fault
			assign fin_used[y] = s.fmr_filt[y] ? s.fin_filt[y] : s.fin_sync[y];
			assign fault_cond[y] = (fin_used[y] == s.fmr_pol[y]);
		end
	endgenerate

	always_comb begin
		logic [31:0] merged;
		logic [31:0] fmr_img;
		merged = 32'h0;
		fmr_img = pair_image('0, '0);
		next_s = s;

		// Write address and data taken in either order
		if (awvalid && s.awready) begin
			next_s.aw_held = 1'b1;
			next_s.aw_addr = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.w_held = 1'b1;
			next_s.w_data = wdata;
			next_s.w_strb = wstrb;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end

		// Deferred selection applied at each channel's period start
		for (int c = 0; c < N_CHAN; c++) begin
			if (period_start[c]) begin
				next_s.sel_high[c] = (s.sel_high[c] | s.pend_set_high[c]) & ~s.pend_clr_high[c];
				next_s.sel_low[c] = (s.sel_low[c] | s.pend_set_low[c]) & ~s.pend_clr_low[c];
				next_s.pend_set_high[c] = 1'b0;
				next_s.pend_set_low[c] = 1'b0;
				next_s.pend_clr_high[c] = 1'b0;
				next_s.pend_clr_low[c] = 1'b0;
			end
		end

		// Status clears first so that a same-cycle event wins
		if (isr_read) begin
			next_s.st.sync_update_write_ready = 1'b0;
			next_s.st.sync_update_underrun = 1'b0;
			next_s.st.cmpm = '0;
			next_s.st.cmpu = '0;
		end
		if (events.program_write) begin
			next_s.st.dma_transmit_end = 1'b0;
		end

		if (wr_fire) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			case (s.aw_addr)
				OFS_ISR2: begin
					// Write-one-to-clear on top of a same-cycle read clear
					next_s.st.sync_update_write_ready = next_s.st.sync_update_write_ready & ~wdat[ST_SYNC_UPDATE_WRITE_READY];
					next_s.st.dma_transmit_end = next_s.st.dma_transmit_end & ~wdat[ST_DMA_TRANSMIT_END];
					next_s.st.sync_update_underrun = next_s.st.sync_update_underrun & ~wdat[ST_SYNC_UPDATE_UNDERRUN];
					next_s.st.cmpm = next_s.st.cmpm & ~wdat[ST_CMPM_LSB +: N_CMP];
					next_s.st.cmpu = next_s.st.cmpu & ~wdat[ST_CMPU_LSB +: N_CMP];
				end
				OFS_OVERRIDE: begin
					merged = (pair_image(s.ovr_high, s.ovr_low) & ~wmask) | wdat;
					next_s.ovr_high = merged[HIGH_LSB +: N_CHAN];
					next_s.ovr_low = merged[LOW_LSB +: N_CHAN];
				end
				OFS_SELECT: begin
					merged = (pair_image(s.sel_high, s.sel_low) & ~wmask) | wdat;
					next_s.sel_high = merged[HIGH_LSB +: N_CHAN];
					next_s.sel_low = merged[LOW_LSB +: N_CHAN];
				end
				OFS_SET_NOW: begin
					next_s.sel_high = next_s.sel_high | wdat[HIGH_LSB +: N_CHAN];
					next_s.sel_low = next_s.sel_low | wdat[LOW_LSB +: N_CHAN];
				end
				OFS_CLEAR_NOW: begin
					next_s.sel_high = next_s.sel_high & ~wdat[HIGH_LSB +: N_CHAN];
					next_s.sel_low = next_s.sel_low & ~wdat[LOW_LSB +: N_CHAN];
				end
				OFS_SET_NEXT: begin
					next_s.pend_set_high = next_s.pend_set_high | wdat[HIGH_LSB +: N_CHAN];
					next_s.pend_set_low = next_s.pend_set_low | wdat[LOW_LSB +: N_CHAN];
					next_s.pend_clr_high = next_s.pend_clr_high & ~wdat[HIGH_LSB +: N_CHAN];
					next_s.pend_clr_low = next_s.pend_clr_low & ~wdat[LOW_LSB +: N_CHAN];
				end
				OFS_CLEAR_NEXT: begin
					next_s.pend_clr_high = next_s.pend_clr_high | wdat[HIGH_LSB +: N_CHAN];
					next_s.pend_clr_low = next_s.pend_clr_low | wdat[LOW_LSB +: N_CHAN];
					next_s.pend_set_high = next_s.pend_set_high & ~wdat[HIGH_LSB +: N_CHAN];
					next_s.pend_set_low = next_s.pend_set_low & ~wdat[LOW_LSB +: N_CHAN];
				end
				OFS_FAULT_MODE: begin
					if (!soft_protect_group_five && !hard_protect_group_five) begin
						fmr_img[FAULT_POLARITY_LSB +: N_FAULT] = s.fmr_pol;
						fmr_img[FAULT_LATCH_MODE_LSB +: N_FAULT] = s.fmr_latch;
						fmr_img[FAULT_FILTER_ENABLE_LSB +: N_FAULT] = s.fmr_filt;
						merged = (fmr_img & ~wmask) | wdat;
						next_s.fmr_pol = merged[FAULT_POLARITY_LSB +: N_FAULT];
						next_s.fmr_latch = merged[FAULT_LATCH_MODE_LSB +: N_FAULT];
						next_s.fmr_filt = merged[FAULT_FILTER_ENABLE_LSB +: N_FAULT];
					end
				end
				OFS_IRQ_MASK: begin
					next_s.irq_mask = (s.irq_mask & ~wmask) | wdat;
				end
				default: begin
					next_s.bresp = RESP_SLVERR;
				end
			endcase
		end

		// Hardware sets win over every clear above
		if (events.write_ready) begin
			next_s.st.sync_update_write_ready = 1'b1;
		end
		if (events.counter_zero) begin
			next_s.st.dma_transmit_end = 1'b1;
		end
		if (events.underrun) begin
			next_s.st.sync_update_underrun = 1'b1;
		end
		next_s.st.cmpm = next_s.st.cmpm | events.cmp_match;
		next_s.st.cmpu = next_s.st.cmpu | events.cmp_update;
		next_s.st.dma_buffer_empty = events.buffer_empty;

		if (rd_take) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			case (araddr)
				OFS_ISR2: next_s.rdata = status_image(s.st);
				OFS_OVERRIDE: next_s.rdata = pair_image(s.ovr_high, s.ovr_low);
				OFS_SELECT: next_s.rdata = pair_image(s.sel_high, s.sel_low);
				OFS_SET_NOW, OFS_CLEAR_NOW, OFS_SET_NEXT, OFS_CLEAR_NEXT: next_s.rdata = 32'h0;
				OFS_FAULT_MODE: begin
					fmr_img[FAULT_POLARITY_LSB +: N_FAULT] = s.fmr_pol;
					fmr_img[FAULT_LATCH_MODE_LSB +: N_FAULT] = s.fmr_latch;
					fmr_img[FAULT_FILTER_ENABLE_LSB +: N_FAULT] = s.fmr_filt;
					next_s.rdata = fmr_img;
				end
				OFS_IRQ_MASK: next_s.rdata = s.irq_mask;
				default: begin
					next_s.rdata = 32'h0;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end

		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready = !next_s.w_held && !next_s.bvalid;
		next_s.arready = !next_s.rvalid;

		// Fault input sync, three-sample filter and activation
		// Stages reset to the idle line level, so reset raises no fault
		next_s.fin_meta = fault_in;
		next_s.fin_sync = s.fin_meta;
		next_s.fin_h1 = s.fin_sync;
		next_s.fin_h2 = s.fin_h1;
		next_s.fin_filt = (s.fin_sync & s.fin_h1 & s.fin_h2)
			| (s.fin_filt & (s.fin_sync | s.fin_h1 | s.fin_h2));
		next_s.fault_act = fault_cond | (s.fmr_latch & s.fault_act & ~fault_clear);

		next_s.pins.high = (s.sel_high & s.ovr_high) | (~s.sel_high & deadtime.high);
		next_s.pins.low = (s.sel_low & s.ovr_low) | (~s.sel_low & deadtime.low);
		next_s.irq = |(status_image(next_s.st) & next_s.irq_mask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rresp = s.rresp;
	assign rdata = s.rdata;
	assign pins = s.pins;
	assign fault_active = s.fault_act;
	assign irq = s.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_ready_flag_set: assert property (events.write_ready |=> s.st.sync_update_write_ready)
		else $error("write-ready flag not set");
	a_dma_transmit_end_follows: assert property (events.counter_zero |=> s.st.dma_transmit_end ##0
		(status_image(s.st) & 32'h2) == 32'h2)
		else $error("end-of-buffer flag not set");
	a_dma_transmit_end_cleared: assert property ((events.program_write && !events.counter_zero)
		|=> !s.st.dma_transmit_end)
		else $error("end-of-buffer flag not cleared");
	a_underrun_sticky: assert property ((s.st.sync_update_underrun && !isr_read && !(wr_fire &&
		s.aw_addr == OFS_ISR2)) |=> s.st.sync_update_underrun)
		else $error("underrun flag lost");
	a_match_sticky: assert property ((events.cmp_match != 8'h00) |=>
		((s.st.cmpm & $past(events.cmp_match)) == $past(events.cmp_match)))
		else $error("match flag not captured");
	a_update_sticky: assert property ((events.cmp_update != 8'h00) |=>
		((s.st.cmpu & $past(events.cmp_update)) == $past(events.cmp_update)))
		else $error("update flag not captured");
	a_read_clears: assert property ((isr_read && !events.write_ready && !events.underrun
		&& events.cmp_match == 8'h00 && events.cmp_update == 8'h00) |=>
		(!s.st.sync_update_write_ready && !s.st.sync_update_underrun && s.st.cmpm == 8'h00 && s.st.cmpu == 8'h00))
		else $error("status read did not clear flags");
	a_override_drive: assert property ((s.sel_high[0] && s.ovr_high[0]) |=> pins.high[0])
		else $error("override level not driven");
	a_deadtime_drive: assert property ((!s.sel_low[1] && deadtime.low[1]) |=> pins.low[1])
		else $error("dead-time output not routed");
	a_set_now: assert property ((wr_fire && s.aw_addr == OFS_SET_NOW && s.w_strb == 4'hF)
		|=> ((s.sel_high & $past(s.w_data[3:0])) == $past(s.w_data[3:0])))
		else $error("immediate set not applied");
	a_clear_now: assert property ((wr_fire && s.aw_addr == OFS_CLEAR_NOW && s.w_strb == 4'hF)
		|=> ((s.sel_low & $past(s.w_data[19:16])) == 4'h0))
		else $error("immediate clear not applied");
	a_select_holds: assert property ((!wr_fire && period_start == 4'h0) |=>
		(s.sel_high == $past(s.sel_high) && s.sel_low == $past(s.sel_low)))
		else $error("selection changed without cause");
	a_deferred_set: assert property ((period_start[1] && s.pend_set_high[1] && !wr_fire)
		|=> s.sel_high[1] ##1 pins.high[1] == $past(s.ovr_high[1]))
		else $error("deferred set not applied");
	a_deferred_clear: assert property ((period_start[0] && s.pend_clr_low[0] && !wr_fire)
		|=> !s.sel_low[0])
		else $error("deferred clear not applied");
	a_mode_protected: assert property ((wr_fire && s.aw_addr == OFS_FAULT_MODE &&
		(soft_protect_group_five || hard_protect_group_five)) |=>
		$stable({s.fmr_pol, s.fmr_latch, s.fmr_filt}))
		else $error("protected fault mode was written");
	a_fault_follow: assert property ((s.fmr_latch == 6'h00) |=>
		(s.fault_act == $past(fault_cond)))
		else $error("unlatched fault does not follow input");
	a_fault_latched: assert property (1'b1 |=>
		(($past(s.fault_act & s.fmr_latch & ~fault_clear) & ~s.fault_act) == 6'h00))
		else $error("latched fault released early");
	a_filter_hold: assert property ((s.fmr_filt[0] && (s.fin_sync[0] != s.fin_h1[0]
		|| s.fin_h1[0] != s.fin_h2[0])) |=> s.fin_filt[0] == $past(s.fin_filt[0]))
		else $error("filtered input moved on unequal samples");

	// Flag, readback, selection and fault checks beyond the basic ones
	a_underrun_set: assert property (events.underrun |=> s.st.sync_update_underrun)
		else $error("underrun flag not set");
	a_dma_buffer_empty_mirror: assert property (1'b1 |=>
		(s.st.dma_buffer_empty == $past(events.buffer_empty)))
		else $error("buffer-empty flag does not follow its level");
	a_read_returns: assert property (isr_read |=>
		(rdata == status_image($past(s.st))))
		else $error("status read did not return the flags before clearing");
	a_mode_written: assert property ((wr_fire && s.aw_addr == OFS_FAULT_MODE &&
		s.w_strb == 4'hF && !soft_protect_group_five && !hard_protect_group_five) |=>
		(s.fmr_pol == $past(s.w_data[FAULT_POLARITY_LSB +: N_FAULT]) &&
		s.fmr_latch == $past(s.w_data[FAULT_LATCH_MODE_LSB +: N_FAULT])))
		else $error("unprotected fault mode write lost");
	a_fault_holds: assert property (fault_cond[0] |=> s.fault_act[0])
		else $error("fault released while its condition stands");
	a_low_deferred: assert property ((period_start[1] && s.pend_set_low[1]
		&& !wr_fire) |=> s.sel_low[1])
		else $error("deferred low-side set not applied");
	a_clear_high: assert property ((wr_fire && s.aw_addr == OFS_CLEAR_NOW
		&& s.w_strb == 4'hF) |=> ((s.sel_high & $past(s.w_data[3:0])) == 4'h0))
		else $error("immediate high-side clear not applied");
	a_irq_level: assert property (irq == |(status_image(s.st) & s.irq_mask))
		else $error("interrupt does not match unmasked status");

	c_status_read: cover property (s.st.cmpm != 8'h00 ##1 isr_read);
	c_deferred_set: cover property (s.pend_set_high[0] ##1 period_start[0] ##1 s.sel_high[0]);
	c_fault_latched: cover property (s.fmr_latch[0] && s.fault_act[0] && !fault_cond[0]);
	c_protect_write: cover property (wr_fire && s.aw_addr == OFS_FAULT_MODE && soft_protect_group_five);
	c_irq_raise: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// *** test/pwo_power_stage.sv ***
// Power stage model: open-drain fault lines with pull-ups
`timescale 1ns/10ps
`default_nettype none
module pwo_power_stage
	import pwo_pkg::*;
(
	input wire logic aclk,
	input wire pwo_pkg::pwo_pins_t pins,
	input wire logic [pwo_pkg::N_FAULT-1:0] trip,
	output logic [pwo_pkg::N_FAULT-1:0] fault_n,
	output logic shoot_through
);
	// Pull-up holds a line high unless the stage pulls it down
	assign fault_n = ~trip;
	// Both switches of one leg on together
	always_ff @(posedge aclk) begin
		shoot_through <= |(pins.high & pins.low);
	end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench of the PWM output override block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pwo_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, soft_p, hard_p, seen;
	logic [31:0] awaddr, wdata, araddr, rdata, rd, v, s, c, o;
	logic [3:0] wstrb, period_start, be;
	logic [1:0] bresp, rresp, resp;
	logic [5:0] fault_n, fault_clear, trip, fault_active;
	pwo_pins_t deadtime, pins;
	pwo_events_t events, e;
	int n_mismatch = 0, checks_done = 0, cycles = 0, seed = 32'hd75a1244;

	pwo_top pwo_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.deadtime(deadtime), .period_start(period_start), .events(events),
		.fault_in(fault_n), .fault_clear(fault_clear), .soft_protect_group_five(soft_p),
		.hard_protect_group_five(hard_p), .pins(pins), .fault_active(fault_active), .irq(irq));
	pwo_power_stage pwo_power_stage_i (.aclk(aclk), .pins(pins), .trip(trip),
		.fault_n(fault_n), .shoot_through());

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= be;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		hb = 1'b0;
		while (!hb) begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid && bready;
			resp = bresp;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask

	task automatic rdr(input logic [31:0] a);
		logic ha, hr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		hr = 1'b0;
		while (!hr) begin
			@(negedge aclk);
			ha = arvalid && arready;
			hr = rvalid && rready;
			rd = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ha) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask

	task automatic pulse(input pwo_events_t ev, input logic [3:0] p);
		pwo_events_t rest;
		rest = '0;
		rest.buffer_empty = ev.buffer_empty;
		@(posedge aclk);
		events <= ev;
		period_start <= p;
		@(posedge aclk);
		events <= rest;
		period_start <= 4'h0;
	endtask

	task automatic pin_chk(input logic [31:0] sel, input logic [31:0] ovr);
		pwo_pins_t x;
		repeat (3) @(posedge aclk);
		x.high = (sel[3:0] & ovr[3:0]) | (~sel[3:0] & deadtime.high);
		x.low = (sel[19:16] & ovr[19:16]) | (~sel[19:16] & deadtime.low);
		@(negedge aclk);
		chk({24'h0, pins}, {24'h0, x});
		@(posedge aclk);
	endtask

	task automatic fchk(input logic [5:0] exp);
		repeat (6) @(posedge aclk);
		@(negedge aclk);
		chk({26'h0, fault_active}, {26'h0, exp});
		@(posedge aclk);
	endtask

	initial begin
		aresetn = 1'b0;
		{awaddr, wdata, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
		{deadtime, period_start, events, fault_clear, trip, soft_p, hard_p} = '0;
		be = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// No fault may show while the sampling stages settle after reset
		repeat (3) begin
			@(negedge aclk);
			chk({26'h0, fault_active}, 32'h0);
		end
		// Reset values, then unmapped place
		for (int i = 0; i < 8; i++) begin
			rdr(OFS_ISR2 + 32'(4 * i));
			chk(rd, 32'h0);
		end
		rdr(OFS_IRQ_MASK);
		chk(rd, 32'h0);
		rdr(32'h40020100);
		chk(rd, 32'h0);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(32'h40020100, 32'hFFFFFFFF);
		chk({30'h0, resp}, {30'h0, RESP_SLVERR});
		// Random levels and selections, all-override first
		for (int i = 0; i < 6; i++) begin
			o = $random(seed) & 32'h000F000F;
			s = (i == 0) ? 32'h000F000F : ($random(seed) & 32'h000F000F);
			deadtime <= pwo_pins_t'(8'($random(seed)));
			wr(OFS_OVERRIDE, o);
			wr(OFS_SELECT, s);
			rdr(OFS_OVERRIDE);
			chk(rd, o);
			rdr(OFS_SELECT);
			chk(rd, s);
			pin_chk(s, o);
		end
		// Byte strobes: only the low-side byte of the override levels changes
		be = 4'h4;
		wr(OFS_OVERRIDE, 32'h000F000F);
		be = 4'hF;
		o = (o & 32'h0000000F) | 32'h000F0000;
		rdr(OFS_OVERRIDE);
		chk(rd, o);
		wr(OFS_SELECT, 32'h0);
		s = 32'h0;
		for (int i = 0; i < 4; i++) begin
			v = $random(seed) & 32'h000F000F;
			c = $random(seed) & 32'h000F000F;
			wr(OFS_SET_NOW, v);
			s = s | v;
			rdr(OFS_SELECT);
			chk(rd, s);
			wr(OFS_CLEAR_NOW, c);
			s = s & ~c;
			rdr(OFS_SELECT);
			chk(rd, s);
			pin_chk(s, o);
		end
		// Deferred changes wait for each channel's own period start
		wr(OFS_SELECT, 32'h0);
		wr(OFS_SET_NEXT, 32'h00030003);
		rdr(OFS_SELECT);
		chk(rd, 32'h0);
		pulse('0, 4'h1);
		rdr(OFS_SELECT);
		chk(rd, 32'h00010001);
		pulse('0, 4'h2);
		rdr(OFS_SELECT);
		chk(rd, 32'h00030003);
		wr(OFS_CLEAR_NEXT, 32'h00010001);
		pulse('0, 4'h2);
		rdr(OFS_SELECT);
		chk(rd, 32'h00030003);
		pulse('0, 4'h1);
		rdr(OFS_SELECT);
		chk(rd, 32'h00020002);
		// Status flags, read clearing and interrupt
		wr(OFS_IRQ_MASK, 32'h00000100);
		e = '0;
		e.cmp_match = 8'($random(seed)) | 8'h01;
		e.cmp_update = 8'($random(seed));
		e.underrun = 1'b1;
		e.write_ready = 1'b1;
		pulse(e, 4'h0);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk({31'h0, irq}, 32'h1);
		rdr(OFS_ISR2);
		chk(rd, {8'h0, e.cmp_update, e.cmp_match, 8'h09});
		rdr(OFS_ISR2);
		chk(rd, 32'h0);
		@(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		e = '0;
		e.cmp_match = 8'h02;
		pulse(e, 4'h0);
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		rdr(OFS_ISR2);
		chk(rd, 32'h00000200);
		// Underrun flag cleared by writing a one to it, end-of-buffer flag by DMA programming
		e = '0;
		e.underrun = 1'b1;
		pulse(e, 4'h0);
		wr(OFS_ISR2, 32'h00000008);
		rdr(OFS_ISR2);
		chk(rd, 32'h0);
		e = '0;
		e.counter_zero = 1'b1;
		e.buffer_empty = 1'b1;
		pulse(e, 4'h0);
		rdr(OFS_ISR2);
		chk(rd, 32'h6);
		rdr(OFS_ISR2);
		chk(rd, 32'h6);
		e = '0;
		e.program_write = 1'b1;
		pulse(e, 4'h0);
		rdr(OFS_ISR2);
		chk(rd, 32'h0);
		// Fault mode under each protection, then fault behaviour
		soft_p <= 1'b1;
		wr(OFS_FAULT_MODE, 32'h003F3F3F);
		rdr(OFS_FAULT_MODE);
		chk(rd, 32'h0);
		soft_p <= 1'b0;
		hard_p <= 1'b1;
		wr(OFS_FAULT_MODE, 32'h003F3F3F);
		rdr(OFS_FAULT_MODE);
		chk(rd, 32'h0);
		hard_p <= 1'b0;
		wr(OFS_FAULT_MODE, 32'h1);
		rdr(OFS_FAULT_MODE);
		chk(rd, 32'h1);
		fchk(6'h01);
		wr(OFS_FAULT_MODE, 32'h0);
		fchk(6'h00);
		trip <= 6'h01;
		fchk(6'h01);
		trip <= 6'h00;
		fchk(6'h00);
		wr(OFS_FAULT_MODE, 32'h100);
		trip <= 6'h01;
		fchk(6'h01);
		trip <= 6'h00;
		fchk(6'h01);
		@(posedge aclk);
		fault_clear <= 6'h01;
		@(posedge aclk);
		fault_clear <= 6'h00;
		fchk(6'h00);
		wr(OFS_FAULT_MODE, 32'h10000);
		trip <= 6'h01;
		@(posedge aclk);
		trip <= 6'h00;
		seen = 1'b0;
		repeat (8) begin
			@(negedge aclk);
			seen = seen | fault_active[0];
		end
		chk({31'h0, seen}, 32'h0);
		@(posedge aclk);
		trip <= 6'h01;
		fchk(6'h01);
		summarize();
	end
endmodule
`default_nettype wire
